// file: rtl/psom_pkg.sv
// Constants and carriers of the parameter object map and store sequencer.
// Assumes one 125 MHz clock and a word-wide nonvolatile memory port.
package psom_pkg;
    localparam int          FAM_N = 9;
    localparam logic [15:0] FAM_BASE [FAM_N] = '{16'h2001, 16'h2081, 16'h2101,
        16'h2181, 16'h2201, 16'h2281, 16'h2401, 16'h2481, 16'h2581};
    localparam logic [15:0] FAM_LAST [FAM_N] = '{16'h2020, 16'h20c0, 16'h2150,
        16'h21b0, 16'h2240, 16'h22c0, 16'h2430, 16'h24d0, 16'h25a0};
    localparam int          PARAM_WORDS = 512;
    localparam int          PA_W        = 9;
    localparam int          WORD_W      = 32;
    localparam int          FIFO_DEPTH  = 16;
    localparam int          NV_W        = 12;

    localparam logic [15:0] STORE_INDEX   = 16'h1010;
    localparam logic [7:0]  SUB_COUNT     = 8'h00;
    localparam logic [7:0]  SUB_SAVE_ALL  = 8'h01;
    localparam logic [7:0]  STORE_ENTRIES = 8'h01;
    localparam logic [31:0] SAVE_KEY      = 32'h65766173;
    localparam int          READY_BIT     = 0;
    localparam int          AUTO_BIT      = 1;

    localparam logic [1:0]  SET_PARAM = 2'h1;
    localparam logic [1:0]  SET_POINT = 2'h2;
    localparam logic [1:0]  SET_CAM   = 2'h3;
    localparam logic [NV_W-1:0] NV_BASE_PARAM = 12'h000;
    localparam logic [NV_W-1:0] NV_BASE_POINT = 12'h200;
    localparam logic [NV_W-1:0] NV_BASE_CAM   = 12'h300;
    localparam logic [NV_W-1:0] CNT_PARAM     = 12'h200;
    localparam logic [NV_W-1:0] CNT_POINT     = 12'h100;
    localparam logic [NV_W-1:0] CNT_CAM       = 12'h400;

    localparam longint      CLK_HZ        = 125_000_000;
    localparam longint      STORE_MAX_S   = 25;
    localparam longint      STORE_MAX_CYC = STORE_MAX_S * CLK_HZ;

    typedef enum logic [2:0] {
        PSOM_LOAD    = 3'b000,
        PSOM_IDLE    = 3'b001,
        PSOM_STORE   = 3'b011,
        PSOM_BACKUP  = 3'b101,
        PSOM_RESTORE = 3'b100
    } psom_state_e;

    typedef struct packed {
        logic        we;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [31:0] wdata;
    } psom_obj_req_s;

    typedef struct packed {
        logic       restore;
        logic [1:0] set;
        logic       local_conn;
    } psom_ses_req_s;
endpackage

// file: rtl/psom_store_map.sv
// Parameter object map, nonvolatile store/load sequencer, backup/restore streams.
// Assumes a nonvolatile memory with held-request/ack word ports on the same clock.
`timescale 1ns/1ps

module psom_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
    logic          push;
    logic          pop;

    assign in_ready  = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

module psom_store_map
    import psom_pkg::*;
#(
    parameter logic [31:0] STORE_LIMIT = STORE_MAX_CYC[31:0]
) (
    input  wire logic            clock,
    input  wire logic            nrst,
    input  wire logic            obj_req_valid,
    input  wire psom_obj_req_s   obj_req,
    output logic                 obj_ack,
    output logic                 obj_err,
    output logic [31:0]          obj_rdata,
    input  wire logic            ses_start,
    input  wire psom_ses_req_s   ses_req,
    input  wire logic            io_mode_pin,
    output logic                 ses_accept,
    output logic                 ses_refused,
    output logic                 ses_busy,
    output logic                 ses_done,
    output logic                 bk_valid,
    input  wire logic            bk_ready,
    output logic [WORD_W-1:0]    bk_data,
    input  wire logic            rs_valid,
    output logic                 rs_ready,
    input  wire logic [WORD_W-1:0] rs_data,
    output logic                 nvm_rreq,
    output logic [NV_W-1:0]      nvm_raddr,
    input  wire logic            nvm_rack,
    input  wire logic [WORD_W-1:0] nvm_rdata,
    output logic                 nvm_wreq,
    output logic [NV_W-1:0]      nvm_waddr,
    output logic [WORD_W-1:0]    nvm_wdata,
    input  wire logic            nvm_wack,
    output logic                 store_overrun
);
    psom_state_e       state;
    psom_state_e       next_state;
    logic [WORD_W-1:0] param_mem [PARAM_WORDS];
    logic [1:0]        cur_set;
    logic [NV_W-1:0]   src_cnt;
    logic [NV_W-1:0]   snk_cnt;
    logic [NV_W-1:0]   total;
    logic [NV_W-1:0]   base;
    logic [31:0]       store_cyc;
    logic              io_m1;
    logic              io_mode_s;
    logic              src_more;
    logic              fifo_in_valid;
    logic              fifo_in_ready;
    logic [WORD_W-1:0] fifo_in_data;
    logic              fifo_out_valid;
    logic              fifo_out_ready;
    logic [WORD_W-1:0] fifo_out_data;
    logic              wr_mode;
    logic              rd_mode;
    logic              snk_adv;
    logic              last;
    logic              timeout;
    logic              is_store;
    logic              pm_hit;
    logic [PA_W-1:0]   pm_addr;
    logic              save_cmd;
    logic              ses_ok;
    logic              param_wr;

    // Family ranges are packed back to back into one working array
    function automatic logic [PA_W:0] map_index(input logic [15:0] idx);
        logic [PA_W:0] res;
        int            off;
        res = '0;
        off = 0;
        for (int f = 0; f < FAM_N; f++) begin
            if (idx >= FAM_BASE[f] && idx <= FAM_LAST[f]) begin
                res = {1'b1, PA_W'(off + int'(idx - FAM_BASE[f]))};
            end
            off = off + int'(FAM_LAST[f] - FAM_BASE[f]) + 1;
        end
        return res;
    endfunction

    always_ff @(posedge clock) begin
        if (!nrst) begin
            io_m1     <= 1'b0;
            io_mode_s <= 1'b0;
        end else begin
            io_m1     <= io_mode_pin;
            io_mode_s <= io_m1;
        end
    end

    assign {pm_hit, pm_addr} = map_index(obj_req.index);
    assign is_store = (obj_req.index == STORE_INDEX);
    assign save_cmd = obj_req_valid && obj_req.we && is_store && obj_req.sub == SUB_SAVE_ALL
                      && obj_req.wdata == SAVE_KEY && state == PSOM_IDLE;
    // Sessions need a free drive, a remote link and I/O mode for cam data
    assign ses_ok = ses_start && state == PSOM_IDLE && !save_cmd
                    && !ses_req.local_conn
                    && ses_req.set != 2'h0
                    && !(ses_req.set == SET_CAM && !io_mode_s);
    assign param_wr = obj_req_valid && obj_req.we && pm_hit && obj_req.sub == 8'h00
                      && state != PSOM_LOAD;

    always_comb begin
        case (cur_set)
            SET_POINT: begin
                total = CNT_POINT;
                base  = NV_BASE_POINT;
            end
            SET_CAM: begin
                total = CNT_CAM;
                base  = NV_BASE_CAM;
            end
            default: begin
                total = CNT_PARAM;
                base  = NV_BASE_PARAM;
            end
        endcase
    end

    assign wr_mode  = (state == PSOM_STORE) || (state == PSOM_RESTORE);
    assign rd_mode  = (state == PSOM_LOAD) || (state == PSOM_BACKUP);
    assign src_more = (src_cnt < total);

    always_comb begin
        fifo_in_valid = 1'b0;
        fifo_in_data  = nvm_rdata;
        case (state)
            PSOM_STORE: begin
                fifo_in_valid = src_more;
                fifo_in_data  = param_mem[src_cnt[PA_W-1:0]];
            end
            PSOM_RESTORE: begin
                fifo_in_valid = src_more && rs_valid;
                fifo_in_data  = rs_data;
            end
            PSOM_LOAD, PSOM_BACKUP: begin
                fifo_in_valid = nvm_rack;
            end
            default: begin
                fifo_in_valid = 1'b0;
            end
        endcase
    end

    assign rs_ready  = (state == PSOM_RESTORE) && src_more && fifo_in_ready;
    assign nvm_rreq  = rd_mode && src_more && fifo_in_ready;
    assign nvm_raddr = base + src_cnt;

    psom_fifo #(
        .W     (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock     (clock),
        .nrst      (nrst),
        .flush     (timeout),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    assign nvm_wreq  = wr_mode && fifo_out_valid;
    assign nvm_waddr = base + snk_cnt;
    assign nvm_wdata = fifo_out_data;
    assign bk_valid  = (state == PSOM_BACKUP) && fifo_out_valid;
    assign bk_data   = fifo_out_data;
    assign fifo_out_ready = (wr_mode && nvm_wack) || ((state == PSOM_BACKUP) && bk_ready)
                            || (state == PSOM_LOAD);
    assign snk_adv = fifo_out_valid && fifo_out_ready;
    // A set ends once its last word has left the buffer, or a store ends early on timeout
    assign last    = snk_adv && (snk_cnt == total - 1'b1);
    assign timeout = (state == PSOM_STORE) && (store_cyc >= STORE_LIMIT - 1);

    always_comb begin
        next_state = state;
        case (state)
            PSOM_LOAD: begin
                if (last) begin
                    next_state = PSOM_IDLE;
                end
            end
            PSOM_IDLE: begin
                if (save_cmd) begin
                    next_state = PSOM_STORE;
                end else if (ses_ok) begin
                    next_state = ses_req.restore ? PSOM_RESTORE : PSOM_BACKUP;
                end
            end
            PSOM_STORE: begin
                if (last || timeout) begin
                    next_state = PSOM_IDLE;
                end
            end
            PSOM_BACKUP, PSOM_RESTORE: begin
                if (last) begin
                    next_state = PSOM_IDLE;
                end
            end
            default: begin
                next_state = PSOM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            state <= PSOM_LOAD;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            cur_set <= SET_PARAM;
        end else if (save_cmd) begin
            cur_set <= SET_PARAM;
        end else if (ses_ok) begin
            cur_set <= ses_req.set;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst || next_state != state) begin
            src_cnt <= '0;
            snk_cnt <= '0;
        end else begin
            if (fifo_in_valid && fifo_in_ready) begin
                src_cnt <= src_cnt + 1'b1;
            end
            if (snk_adv) begin
                snk_cnt <= snk_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst || state != PSOM_STORE) begin
            store_cyc <= '0;
        end else begin
            store_cyc <= store_cyc + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            store_overrun <= 1'b0;
        end else if (timeout) begin
            store_overrun <= 1'b1;
        end else if (save_cmd) begin
            store_overrun <= 1'b0;
        end
    end

    // Working copy only; power loss drops it unless a store follows
    always_ff @(posedge clock) begin
        if (state == PSOM_LOAD && snk_adv) begin
            param_mem[snk_cnt[PA_W-1:0]] <= fifo_out_data;
        end else if (param_wr) begin
            param_mem[pm_addr] <= obj_req.wdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            obj_ack   <= 1'b0;
            obj_err   <= 1'b0;
            obj_rdata <= 32'h0000_0000;
        end else begin
            obj_ack   <= obj_req_valid;
            obj_err   <= 1'b0;
            obj_rdata <= 32'h0000_0000;
            if (obj_req_valid) begin
                if (state == PSOM_LOAD) begin
                    obj_err <= 1'b1;
                end else if (is_store && obj_req.sub == SUB_COUNT) begin
                    obj_rdata <= {24'h000000, STORE_ENTRIES};
                end else if (is_store && obj_req.sub == SUB_SAVE_ALL) begin
                    obj_rdata[READY_BIT] <= (state == PSOM_IDLE);
                    obj_rdata[AUTO_BIT]  <= 1'b0;
                end else if (pm_hit && obj_req.sub == 8'h00) begin
                    obj_rdata <= obj_req.we ? 32'h0000_0000 : param_mem[pm_addr];
                end else begin
                    obj_err <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            ses_accept  <= 1'b0;
            ses_refused <= 1'b0;
            ses_done    <= 1'b0;
        end else begin
            ses_accept  <= ses_ok;
            ses_refused <= ses_start && !ses_ok;
            ses_done    <= last && (state == PSOM_BACKUP || state == PSOM_RESTORE);
        end
    end

    assign ses_busy = (state == PSOM_BACKUP) || (state == PSOM_RESTORE);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    sequence s_key_write;
        obj_req_valid && obj_req.we && is_store && obj_req.sub == SUB_SAVE_ALL
            && obj_req.wdata == SAVE_KEY;
    endsequence

    sequence s_status_read;
        obj_req_valid && !obj_req.we && is_store && obj_req.sub == SUB_SAVE_ALL;
    endsequence

    property p_key_starts_store;
        s_key_write ##0 (state == PSOM_IDLE) |=> (state == PSOM_STORE) [*2];
    endproperty
    a_key_starts_store: assert property (p_key_starts_store) else $error("key did not start store");

    property p_bad_key_ignored;
        obj_req_valid && obj_req.we && is_store && obj_req.wdata != SAVE_KEY
            && state == PSOM_IDLE && !ses_start |=> state == PSOM_IDLE && !nvm_wreq;
    endproperty
    a_bad_key_ignored: assert property (p_bad_key_ignored) else $error("non-key write started save");

    property p_ready_bit;
        s_status_read ##0 (state != PSOM_LOAD) |=> obj_ack && obj_rdata[READY_BIT] == ($past(state) == PSOM_IDLE);
    endproperty
    a_ready_bit: assert property (p_ready_bit) else $error("ready bit wrong");

    property p_auto_bit;
        s_status_read |=> !obj_rdata[AUTO_BIT];
    endproperty
    a_auto_bit: assert property (p_auto_bit) else $error("auto-save bit set");

    property p_sub0_count;
        obj_req_valid && is_store && obj_req.sub == SUB_COUNT && state != PSOM_LOAD
            |=> !obj_err && obj_rdata == {24'h000000, STORE_ENTRIES}
                && !(state == PSOM_STORE && $past(state) == PSOM_IDLE);
    endproperty
    a_sub0_count: assert property (p_sub0_count) else $error("entry count wrong");

    property p_no_auto_write;
        nvm_wreq |-> state == PSOM_STORE || state == PSOM_RESTORE;
    endproperty
    a_no_auto_write: assert property (p_no_auto_write) else $error("unrequested nvm write");

    property p_local_refused;
        ses_start && ses_req.local_conn |=> ses_refused && !ses_accept && !$rose(ses_busy);
    endproperty
    a_local_refused: assert property (p_local_refused) else $error("local session accepted");

    property p_cam_io_only;
        ses_start && ses_req.set == SET_CAM && !io_mode_s |=> ses_refused && !$rose(ses_busy);
    endproperty
    a_cam_io_only: assert property (p_cam_io_only) else $error("cam set outside I/O mode");

    property p_one_session;
        ses_start && ses_busy |=> ses_refused ##0 $stable(cur_set);
    endproperty
    a_one_session: assert property (p_one_session) else $error("second session accepted");

    property p_store_bound;
        state == PSOM_STORE |-> store_cyc < STORE_LIMIT;
    endproperty
    a_store_bound: assert property (p_store_bound) else $error("store exceeded limit");

    property p_load_first;
        $past(!nrst) |-> state == PSOM_LOAD && !nvm_wreq;
    endproperty
    a_load_first: assert property (p_load_first) else $error("no load after reset");

    property p_set_complete;
        ses_done |-> $past(snk_cnt) == $past(total) - 1'b1;
    endproperty
    a_set_complete: assert property (p_set_complete) else $error("set ended early");
endmodule

// file: verif/psom_nvm_model.sv
// Behavioural nonvolatile memory on the far side of the store sequencer.
// Assumes held read/write requests; slow high inserts random stalls.
`timescale 1ns/1ps

module psom_nvm_model
    import psom_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              slow,
    input  wire logic              nvm_rreq,
    input  wire logic [NV_W-1:0]   nvm_raddr,
    output logic                   nvm_rack,
    output logic [WORD_W-1:0]      nvm_rdata,
    input  wire logic              nvm_wreq,
    input  wire logic [NV_W-1:0]   nvm_waddr,
    input  wire logic [WORD_W-1:0] nvm_wdata,
    output logic                   nvm_wack
);
    logic [WORD_W-1:0] mem [1 << NV_W];
    logic [15:0]       lfsr;
    int                n_wr;

    initial begin
        for (int i = 0; i < (1 << NV_W); i++) begin
            mem[i] = i * 32'h9e3779b1 ^ 32'h0f1e2d3c;
        end
        n_wr = 0;
        lfsr = 16'hace1;
        nvm_rack = 1'b0;
        nvm_wack = 1'b0;
        nvm_rdata = '0;
    end

    always @(posedge clock) begin
        lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    end

    // Never acks twice in a row, so a held request is taken once
    always @(posedge clock) begin
        nvm_rack <= nvm_rreq && !nvm_rack && !(slow && lfsr[0]);
        if (nvm_rreq && !nvm_rack && !(slow && lfsr[0])) begin
            nvm_rdata <= mem[nvm_raddr];
        end else begin
            nvm_rdata <= ~nvm_rdata;
        end
    end

    always @(posedge clock) begin
        nvm_wack <= nvm_wreq && !nvm_wack && !(slow && lfsr[1]);
        if (nvm_wreq && !nvm_wack && !(slow && lfsr[1])) begin
            mem[nvm_waddr] <= nvm_wdata;
            n_wr <= n_wr + 1;
        end
    end
endmodule

// file: verif/psom_store_map_tb.sv
// Self-checking bench for the parameter store map.
// Assumes the memory model holds the saved data and answers held requests.
`timescale 1ns/1ps

module psom_store_map_tb;
    import psom_pkg::*;
    logic              clock, nrst, obj_req_valid, obj_ack, obj_err, ses_start, io_mode_pin, er, slow;
    logic              ses_accept, ses_refused, ses_busy, ses_done, bk_valid, bk_ready, rs_valid, rs_ready;
    logic              nvm_rreq, nvm_rack, nvm_wreq, nvm_wack, store_overrun;
    logic [NV_W-1:0]   nvm_raddr, nvm_waddr;
    logic [31:0]       obj_rdata, bk_data, rs_data, nvm_rdata, nvm_wdata, rd, v;
    logic [31:0]       exp_w [PARAM_WORDS];
    logic [31:0]       bk_q [$];
    psom_obj_req_s     obj_req;
    psom_ses_req_s     ses_req;
    int                n_mismatch, n_tests, t, f, off, wr0;

    psom_store_map #(.STORE_LIMIT(32'd4000)) psom_store_map_inst (.*);
    psom_nvm_model psom_nvm_model_inst (.*);

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        if (bk_valid && bk_ready) begin
            bk_q.push_back(bk_data);
        end
    end

    function automatic logic [31:0] nv_init(input int a);
        return a * 32'h9e3779b1 ^ 32'h0f1e2d3c;
    endfunction

    function automatic int word_of(input int fam, input int o);
        int w;
        w = o;
        for (int j = 0; j < fam; j++) begin
            w += FAM_LAST[j] - FAM_BASE[j] + 1;
        end
        return w;
    endfunction

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic obj(input logic we, input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] wd);
        @(posedge clock);
        obj_req_valid <= 1'b1;
        obj_req <= '{we: we, index: idx, sub: sub, wdata: wd};
        @(posedge clock);
        obj_req_valid <= 1'b0;
        #1;
        chk("obj_ack", 32'h1, {31'h0, obj_ack});
        rd = obj_rdata;
        er = obj_err;
    endtask

    task automatic idle_wait;
        rd = '0;
        for (t = 0; t < 3000 && rd !== 32'h1; t++) begin
            obj(1'b0, STORE_INDEX, SUB_SAVE_ALL, '0);
        end
        chk("save_ready", 32'h1, rd);
    endtask

    task automatic ses(input logic rs, input logic [1:0] set, input logic loc, input logic acc);
        @(posedge clock);
        ses_start <= 1'b1;
        ses_req <= '{restore: rs, set: set, local_conn: loc};
        @(posedge clock);
        ses_start <= 1'b0;
        #1;
        chk("ses_accept", {31'h0, acc}, {31'h0, ses_accept});
        chk("ses_refused", {31'h0, !acc}, {31'h0, ses_refused});
    endtask

    task automatic xfer(input logic rs, input logic [1:0] set, input int n, input logic [NV_W-1:0] base);
        int i;
        int j;
        i = 0;
        bk_q.delete();
        ses(rs, set, 1'b0, 1'b1);
        ses(rs, set, 1'b0, 1'b0);
        chk("ses_busy", 32'h1, {31'h0, ses_busy});
        // No object traffic while the stream runs
        for (j = 0; j < 20000 && ses_done !== 1'b1; j++) begin
            @(posedge clock);
            if (rs_valid && rs_ready) begin
                i++;
            end
            if (!rs_valid || rs_ready) begin
                rs_valid <= rs && i < n && $urandom_range(0, 7) != 0;
            end
            rs_data <= nv_init(i) ^ 32'h00ff00ff;
            // Stall first so the buffer fills and refuses
            bk_ready <= !rs && j > 40 && $urandom_range(0, 1) == 1;
            #1;
        end
        chk("ses_done", 32'h1, {31'h0, ses_done});
        chk("ses_idle", 32'h0, {31'h0, ses_busy});
        bk_ready <= 1'b0;
        repeat (4) @(posedge clock);
        chk("words", n, rs ? i : bk_q.size());
        for (int k = 0; k < n; k++) begin
            chk("data", rs ? nv_init(k) ^ 32'h00ff00ff : nv_init(base + k),
                rs ? psom_nvm_model_inst.mem[base + k] : bk_q[k]);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge clock);
        n_mismatch++;
        summarize();
    end

    initial begin
        void'($urandom(32'h53bb99f8));
        {nrst, obj_req_valid, ses_start, io_mode_pin, bk_ready, rs_valid, slow} = '0;
        obj_req = '0;
        ses_req = '0;
        rs_data = '0;
        for (int k = 0; k < PARAM_WORDS; k++) begin
            exp_w[k] = nv_init(k);
        end
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        obj(1'b0, 16'h2001, 8'h00, '0);
        chk("err_in_load", 32'h1, {31'h0, er});
        idle_wait();
        chk("nvm_writes", 32'h0, psom_nvm_model_inst.n_wr);
        for (int k = 0; k < FAM_N; k++) begin
            obj(1'b0, FAM_BASE[k], 8'h00, '0);
            chk("first", nv_init(word_of(k, 0)), rd);
            obj(1'b0, FAM_LAST[k], 8'h00, '0);
            chk("last", nv_init(word_of(k, FAM_LAST[k] - FAM_BASE[k])), rd);
            obj(1'b0, FAM_LAST[k] + 16'h1, 8'h00, '0);
            chk("unmapped", 32'h1, {31'h0, er});
        end
        for (int k = 0; k < 24; k++) begin
            f = $urandom_range(0, FAM_N - 1);
            off = $urandom_range(0, FAM_LAST[f] - FAM_BASE[f]);
            v = $urandom();
            obj(1'b1, FAM_BASE[f] + off[15:0], 8'h00, v);
            exp_w[word_of(f, off)] = v;
            obj(1'b0, FAM_BASE[f] + off[15:0], 8'h00, '0);
            chk("readback", v, rd);
        end
        obj(1'b0, 16'h2001, 8'h01, '0);
        chk("sub_err", 32'h1, {31'h0, er});
        obj(1'b1, STORE_INDEX, SUB_COUNT, 32'hff);
        obj(1'b0, STORE_INDEX, SUB_COUNT, '0);
        chk("entry_count", {24'h0, STORE_ENTRIES}, rd);
        obj(1'b1, STORE_INDEX, SUB_SAVE_ALL, SAVE_KEY ^ 32'h1);
        obj(1'b0, STORE_INDEX, SUB_SAVE_ALL, '0);
        chk("no_save", 32'h1, rd);
        repeat (20) @(posedge clock);
        chk("nvm_writes", 32'h0, psom_nvm_model_inst.n_wr);
        slow <= 1'b1;
        ses(1'b0, SET_PARAM, 1'b1, 1'b0);
        ses(1'b0, SET_CAM, 1'b0, 1'b0);
        xfer(1'b0, SET_PARAM, 512, NV_BASE_PARAM);
        @(posedge clock);
        io_mode_pin <= 1'b1;
        repeat (4) @(posedge clock);
        xfer(1'b0, SET_CAM, 1024, NV_BASE_CAM);
        xfer(1'b1, SET_POINT, 256, NV_BASE_POINT);
        slow <= 1'b0;
        idle_wait();
        wr0 = psom_nvm_model_inst.n_wr;
        obj(1'b1, STORE_INDEX, SUB_SAVE_ALL, SAVE_KEY);
        obj(1'b0, STORE_INDEX, SUB_SAVE_ALL, '0);
        chk("busy", 32'h0, rd);
        idle_wait();
        chk("overrun", 32'h0, {31'h0, store_overrun});
        chk("store_words", 32'd512, psom_nvm_model_inst.n_wr - wr0);
        for (int k = 0; k < PARAM_WORDS; k++) begin
            chk("stored", exp_w[k], psom_nvm_model_inst.mem[k]);
        end
        @(posedge clock);
        nrst <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b1;
        idle_wait();
        obj(1'b0, FAM_BASE[f] + off[15:0], 8'h00, '0);
        chk("reload", v, rd);
        summarize();
    end
endmodule
